// ### logic/bcls_pkg.sv
// What this block does
// - Before soft-start, a trip-level setting phase of about 350 us runs with the 13 uA setting current forced.
// - The setting voltage is turned into a 6-bit code that is kept as the overcurrent trip value.
// - The trip reference converter has 63 steps of 6.51 mV, topping out at 403 mV.
// - A counter steps the reference up until the setting comparator crosses, then freezes and is the sense reference.
// - A setting voltage above the top of the range means no current limit at all.
// - Stored codes 0 through 10 give an effective limit threshold of zero.
// - The overcurrent sense is looked at only before the three-quarter point of the on-time.
// - Each on-time is counted in 10 ns quanta and three quarters of it, except for the half pulse, is the next cycle's sense window.
// - A fault is raised when the sensed voltage is above the reference anywhere inside the sense window, in soft-start or normal running only.
// - During soft-start the stored trip level is doubled, and restored once soft-start ends.
// - After a trip the present cycle completes, then one more high-side pulse of half an on-time is issued.
// - After that half pulse both switches are off for four soft-start durations before a new soft-start.
// - The sense path is active only while the high-side switch conducts.
// - One soft-start lasts 5.12 ms and counts ssStep_r through 32 steps; the reference stays at the doubled level throughout.
package bcls_pkg;
  localparam int CLK_FREQ_HZ = 100_000_000;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_FREQ_HZ;
  localparam int ONT_QUANTUM_NS = 10;
  localparam int SET_TIME_US = 350;
  localparam int SET_CYCLES = SET_TIME_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int SS_TIME_NS = 5_120_000;
  localparam int SS_CYCLES = SS_TIME_NS / CLK_PERIOD_NS;
  localparam int SET_CURRENT_UA = 13;
  localparam int DAC_STEP_UV = 6510;
  localparam int DAC_MAX_UV = 403_000;
  localparam int DAC_STEPS = 63;
  localparam int SS_STEPS = 32;
  localparam int RETRY_SS_COUNT = 4;
  localparam int DAC_W = 6;
  localparam int REF_W = DAC_W + 1;
  localparam int ONT_W = 10;
  localparam int TMR_W = 22;
  localparam int SSS_W = 5;
  localparam logic [DAC_W-1:0] DAC_MAX_CODE = 6'h3f;
  localparam logic [DAC_W-1:0] DAC_ZERO_MAX = 6'h0a;
  localparam logic [ONT_W-1:0] ONT_MAX = 10'h3ff;

  typedef enum logic [2:0] {
    ST_SET = 3'b000,
    ST_SOFT = 3'b001,
    ST_RUN = 3'b010,
    ST_FINISH = 3'b011,
    ST_HALF = 3'b100,
    ST_WAIT = 3'b101
  } bcls_state_t;
endpackage

// ### logic/bcls_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
module bcls_sequencer import bcls_pkg::*; #(
  parameter int SET_CYCLES_P = SET_CYCLES,
  parameter int SS_CYCLES_P = SS_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic setCompHigh,
  input wire logic senseOver,
  input wire logic pwmHighReq,
  output logic hsGate_r,
  output logic lsGate_r,
  output logic setCurrentEn_r,
  output logic [REF_W-1:0] refCode_r,
  output logic softStart_r,
  output logic [SSS_W-1:0] ssStep_r,
  output logic noLimit_r,
  output logic trip_r
);
  localparam int DAC_STEP_RAW = SET_CYCLES_P / (DAC_STEPS + 1);
  localparam int DAC_STEP_CYC = (DAC_STEP_RAW < 1) ? 1 : DAC_STEP_RAW;
  localparam int SS_STEP_RAW = SS_CYCLES_P / SS_STEPS;
  localparam int SS_STEP_CYC = (SS_STEP_RAW < 1) ? 1 : SS_STEP_RAW;
  // Enable is registered one clock late, so the phase holds one extra state cycle
  localparam logic [TMR_W-1:0] SET_END = TMR_W'(SET_CYCLES_P);
  localparam logic [TMR_W-1:0] SS_END = TMR_W'(SS_CYCLES_P - 1);
  localparam logic [TMR_W-1:0] WAIT_END = TMR_W'(RETRY_SS_COUNT * SS_CYCLES_P - 1);
  localparam logic [TMR_W-1:0] DSTEP_END = TMR_W'(DAC_STEP_CYC - 1);
  localparam logic [TMR_W-1:0] SSTEP_END = TMR_W'(SS_STEP_CYC - 1);

  bcls_state_t state_r, state_nxt;
  logic [TMR_W-1:0] tmr_r, tmr_nxt, stepTmr_r, stepTmr_nxt;
  logic [DAC_W-1:0] dacCode_r, dacCode_nxt;
  logic frozen_r, frozen_nxt, noLimit_nxt, hs_nxt, ls_nxt, trip_nxt, halfArmed_r, halfArmed_nxt;
  logic [ONT_W-1:0] onCnt_r, onCnt_nxt, window_r, window_nxt, lastOn_r, lastOn_nxt;
  logic [SSS_W-1:0] ssStep_nxt;
  logic [REF_W-1:0] ref_nxt;
  logic senseWin, fault, switching;
  logic [ONT_W+1:0] onTotal;

  ////////////////////////////////////////////////////////////////
  always_comb begin
    state_nxt = state_r;
    tmr_nxt = tmr_r + TMR_W'(1);
    stepTmr_nxt = stepTmr_r;
    dacCode_nxt = dacCode_r;
    frozen_nxt = frozen_r;
    noLimit_nxt = noLimit_r;
    halfArmed_nxt = halfArmed_r;
    ssStep_nxt = ssStep_r;
    hs_nxt = 1'b0;
    // Sense only while high side conducts, inside last window
    senseWin = hsGate_r && (onCnt_r < window_r);
    fault = senseWin && senseOver && !noLimit_r && (state_r == ST_SOFT || state_r == ST_RUN);
    trip_nxt = fault;
    unique case (state_r)
      ST_SET: begin
        stepTmr_nxt = stepTmr_r + TMR_W'(1);
        if (stepTmr_r == DSTEP_END) begin
          stepTmr_nxt = '0;
          if (!frozen_r) begin
            if (setCompHigh) begin
              frozen_nxt = 1'b1;
            end else if (dacCode_r == DAC_MAX_CODE) begin
              frozen_nxt = 1'b1;
              noLimit_nxt = 1'b1;
            end else begin
              dacCode_nxt = dacCode_r + DAC_W'(1);
            end
          end
        end
        if (tmr_r == SET_END) begin
          state_nxt = ST_SOFT;
          tmr_nxt = '0;
          stepTmr_nxt = '0;
          ssStep_nxt = '0;
          // Setting never resolved: treat as over range
          if (!frozen_nxt) begin
            frozen_nxt = 1'b1;
            noLimit_nxt = 1'b1;
          end
        end
      end
      ST_SOFT: begin
        hs_nxt = pwmHighReq;
        stepTmr_nxt = stepTmr_r + TMR_W'(1);
        if (stepTmr_r == SSTEP_END) begin
          stepTmr_nxt = '0;
          if (ssStep_r != '1) begin
            ssStep_nxt = ssStep_r + SSS_W'(1);
          end
        end
        if (fault) begin
          state_nxt = ST_FINISH;
        end else if (tmr_r == SS_END) begin
          state_nxt = ST_RUN;
          tmr_nxt = '0;
        end
      end
      ST_RUN: begin
        hs_nxt = pwmHighReq;
        tmr_nxt = '0;
        if (fault) begin
          state_nxt = ST_FINISH;
        end
      end
      ST_FINISH: begin
        // Let the tripped cycle run to its natural end
        hs_nxt = pwmHighReq;
        tmr_nxt = '0;
        if (hsGate_r && !pwmHighReq) begin
          state_nxt = ST_HALF;
          halfArmed_nxt = 1'b0;
        end
      end
      ST_HALF: begin
        if (!halfArmed_r) begin
          tmr_nxt = '0;
          if (pwmHighReq) begin
            halfArmed_nxt = 1'b1;
            hs_nxt = (lastOn_r >> 1) != '0;
            if ((lastOn_r >> 1) == '0) begin
              state_nxt = ST_WAIT;
            end
          end
        end else if (tmr_r + TMR_W'(1) >= TMR_W'(lastOn_r >> 1)) begin
          state_nxt = ST_WAIT;
          tmr_nxt = '0;
        end else begin
          hs_nxt = 1'b1;
        end
      end
      ST_WAIT: begin
        if (tmr_r == WAIT_END) begin
          state_nxt = ST_SOFT;
          tmr_nxt = '0;
          stepTmr_nxt = '0;
          ssStep_nxt = '0;
        end
      end
      default: begin
        state_nxt = ST_WAIT;
        tmr_nxt = '0;
      end
    endcase
    switching = (state_nxt == ST_SOFT || state_nxt == ST_RUN || state_nxt == ST_FINISH);
    // No dead time here; the gate driver inserts non-overlap
    ls_nxt = switching && !hs_nxt;
  end

  ////////////////////////////////////////////////////////////////
  // On-time in 10 ns quanta: one clock is one quantum
  assign onTotal = (ONT_W+2)'(onCnt_r) + (ONT_W+2)'(1);
  always_comb begin
    onCnt_nxt = '0;
    window_nxt = window_r;
    lastOn_nxt = lastOn_r;
    if (hsGate_r) begin
      onCnt_nxt = (onCnt_r == ONT_MAX) ? onCnt_r : onCnt_r + ONT_W'(1);
      if (!hs_nxt && state_r != ST_HALF) begin
        lastOn_nxt = (onCnt_r == ONT_MAX) ? ONT_MAX : onTotal[ONT_W-1:0];
        window_nxt = ONT_W'((onTotal * (ONT_W+2)'(3)) >> 2);
        onCnt_nxt = '0;
      end
    end
  end

  // Reference: zero band, then doubled while soft-starting
  always_comb begin
    if (dacCode_nxt <= DAC_ZERO_MAX) begin
      ref_nxt = '0;
    end else if (state_nxt == ST_SOFT) begin
      ref_nxt = {dacCode_nxt, 1'b0};
    end else begin
      ref_nxt = {1'b0, dacCode_nxt};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_r <= ST_SET;
      tmr_r <= '0;
      stepTmr_r <= '0;
      dacCode_r <= '0;
      frozen_r <= 1'b0;
      noLimit_r <= 1'b0;
      halfArmed_r <= 1'b0;
      ssStep_r <= '0;
      hsGate_r <= 1'b0;
      lsGate_r <= 1'b0;
      trip_r <= 1'b0;
      onCnt_r <= '0;
      window_r <= '0;
      lastOn_r <= '0;
      refCode_r <= '0;
      setCurrentEn_r <= 1'b0;
      softStart_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      tmr_r <= tmr_nxt;
      stepTmr_r <= stepTmr_nxt;
      dacCode_r <= dacCode_nxt;
      frozen_r <= frozen_nxt;
      noLimit_r <= noLimit_nxt;
      halfArmed_r <= halfArmed_nxt;
      ssStep_r <= ssStep_nxt;
      hsGate_r <= hs_nxt;
      lsGate_r <= ls_nxt;
      trip_r <= trip_nxt;
      onCnt_r <= onCnt_nxt;
      window_r <= window_nxt;
      lastOn_r <= lastOn_nxt;
      refCode_r <= ref_nxt;
      setCurrentEn_r <= (state_nxt == ST_SET);
      softStart_r <= (state_nxt == ST_SOFT);
    end
  end

  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  chk_set_current_end: assert property ($fell(setCurrentEn_r) |-> state_r == ST_SOFT)
    else $error("setting current dropped outside start of soft-start");
  chk_code_frozen: assert property (frozen_r && $past(frozen_r) |-> $stable(dacCode_r))
    else $error("trip code moved after freeze");
  chk_freeze_cause: assert property ($rose(frozen_r) && !noLimit_r |-> $past(setCompHigh))
    else $error("code frozen without comparator crossing");
  chk_no_limit_trip: assert property (noLimit_r |-> !trip_r)
    else $error("trip raised with limit disabled");
  chk_zero_band: assert property (state_r != ST_SET && dacCode_r <= DAC_ZERO_MAX |-> refCode_r == '0)
    else $error("low code gave nonzero reference");
  chk_soft_double: assert property (state_r == ST_SOFT && dacCode_r > DAC_ZERO_MAX
    |-> refCode_r == {dacCode_r, 1'b0})
    else $error("reference not doubled in soft-start");
  chk_run_normal: assert property (state_r == ST_RUN && dacCode_r > DAC_ZERO_MAX
    |-> refCode_r == {1'b0, dacCode_r})
    else $error("reference not restored after soft-start");
  chk_trip_window: assert property (trip_r |-> $past(hsGate_r) && $past(onCnt_r) < $past(window_r)
    && $past(senseOver))
    else $error("trip outside sense window");
  chk_window_calc: assert property ($fell(hsGate_r) && $past(state_r) == ST_RUN && $past(onCnt_r) < ONT_MAX
    |-> window_r == ONT_W'((($past(onCnt_r) + 12'h001) * 12'h003) >> 2))
    else $error("sense window not three quarters of on-time");
  chk_trip_finish: assert property (trip_r |-> state_r == ST_FINISH)
    else $error("trip did not enter cycle completion");
  chk_wait_off: assert property (state_r == ST_WAIT |-> !hsGate_r && !lsGate_r)
    else $error("switch on during retry wait");
  chk_half_len: assert property ($rose(hsGate_r) && state_r == ST_HALF && lastOn_r == 10'h028
    |-> hsGate_r [*8] ##1 hsGate_r [*8] ##1 hsGate_r [*4] ##1 !hsGate_r)
    else $error("half pulse length wrong");

  cov_trip: cover property (trip_r);
  cov_retry: cover property (state_r == ST_WAIT ##1 state_r == ST_SOFT);
  cov_run: cover property (state_r == ST_SOFT ##1 state_r == ST_RUN);
  cov_no_limit: cover property ($rose(noLimit_r));
endmodule
`default_nettype wire

// ### test/bcls_power_stage.sv
`timescale 1ns/1ns
`default_nettype none
module bcls_power_stage import bcls_pkg::*; #(
  parameter int STEP_CYC = 10
) (
  input wire logic clk_sys,
  input wire logic setCurrentEn,
  input wire logic hsGate,
  input wire logic [REF_W-1:0] refCode,
  input wire logic [DAC_W:0] setLevel,
  input wire logic [REF_W-1:0] loadLevel,
  output logic setCompHigh,
  output logic senseOver
);
  int setCnt = 0;
  // Own copy of the ramp; may lead or lag the device by one step
  always @(posedge clk_sys) begin
    setCnt <= setCurrentEn ? setCnt + 1 : 0;
  end
  always_comb begin
    setCompHigh = setCurrentEn && ((setCnt / STEP_CYC) >= int'(setLevel));
    senseOver = hsGate && (loadLevel > refCode);
  end
endmodule
`default_nettype wire

// ### test/buck_current_limit_sequencer_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module buck_current_limit_sequencer_tb_top import bcls_pkg::*;;
  localparam int SETC = 640;
  localparam int SSC = 320;
  logic clk_sys = 1'b0, rst_n = 1'b0, pwmHighReq = 1'b0, setCompHigh, senseOver;
  logic hsGate_r, lsGate_r, setCurrentEn_r, softStart_r, noLimit_r, trip_r;
  logic [REF_W-1:0] refCode_r, loadLevel = 7'h00, refSoft;
  logic [SSS_W-1:0] ssStep_r;
  logic [DAC_W:0] setLevel = 7'h00;
  int n_errors = 0, checks = 0, cyc = 0, tripCnt = 0, hsCnt = 0, lsCnt = 0, n;
  bcls_sequencer #(.SET_CYCLES_P(SETC), .SS_CYCLES_P(SSC)) i_bcls_sequencer (.clk_sys(clk_sys), .rst_n(rst_n),
    .setCompHigh(setCompHigh), .senseOver(senseOver), .pwmHighReq(pwmHighReq), .hsGate_r(hsGate_r),
    .lsGate_r(lsGate_r), .setCurrentEn_r(setCurrentEn_r), .refCode_r(refCode_r), .softStart_r(softStart_r),
    .ssStep_r(ssStep_r), .noLimit_r(noLimit_r), .trip_r(trip_r));
  bcls_power_stage #(.STEP_CYC(SETC / 64)) i_bcls_power_stage (.clk_sys(clk_sys), .setCurrentEn(setCurrentEn_r),
    .hsGate(hsGate_r), .refCode(refCode_r), .setLevel(setLevel), .loadLevel(loadLevel),
    .setCompHigh(setCompHigh), .senseOver(senseOver));
  ////////////////////////////////////////////////////////////
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    tripCnt <= tripCnt + int'(trip_r);
    hsCnt <= hsCnt + int'(hsGate_r);
    lsCnt <= lsCnt + int'(lsGate_r);
  end
  // Long retry waits make a hang look busy, so cap the whole run
  always @(posedge clk_sys) begin
    if (cyc == 20000) begin
      n_errors++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic step(input int cnt);
    repeat (cnt) @(posedge clk_sys);
    #1;
  endtask
  task automatic pulse(input int len, input int loadAt);
    pwmHighReq = 1'b1;
    for (int i = 0; i < len; i++) begin
      if (i == loadAt) loadLevel = 7'h7f;
      step(1);
    end
    pwmHighReq = 1'b0;
    loadLevel = 7'h00;
    step(20);
  endtask
  // Reset, run the setting phase and the whole soft-start, stop at the first cycle after soft-start
  task automatic start(input logic [DAC_W:0] lvl);
    rst_n = 1'b0;
    setLevel = lvl;
    step(6);
    rst_n = 1'b1;
    step(1);
    n = 0;
    while (setCurrentEn_r === 1'b1 && n < 2000) begin
      step(1);
      n++;
    end
    check("setLen", n, SETC);
    check("softOn", softStart_r, 1'b1);
    check("ssStep", ssStep_r, 5'h00);
    refSoft = refCode_r;
    n = 0;
    while (softStart_r === 1'b1 && n < 2000) begin
      step(1);
      n++;
    end
    check("softLen", n, SSC);
    check("ssTop", ssStep_r, 5'h1f);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic test_setting_and_trip();
    start(7'h14);
    check("refDouble", refSoft, {refCode_r[REF_W-2:0], 1'b0});
    check("refFrozen", refCode_r >= 7'h13 && refCode_r <= 7'h16, 1'b1);
    check("limitOn", noLimit_r, 1'b0);
    check("lowOn", lsGate_r, 1'b1);
    tripCnt = 0;
    pulse(40, -1);
    pulse(40, 35);
    check("lateTrip", tripCnt, 0);
    hsCnt = 0;
    pulse(40, 3);
    check("earlyTrip", tripCnt, 1);
    check("finishLen", hsCnt, 40);
    hsCnt = 0;
    lsCnt = 0;
    n = 0;
    pwmHighReq = 1'b1;
    while (softStart_r !== 1'b1 && n < 3000) begin
      step(1);
      n++;
    end
    pwmHighReq = 1'b0;
    check("halfLen", hsCnt, 20);
    check("lowOff", lsCnt, 0);
    check("retryWait", n >= 4 * SSC + 15 && n <= 4 * SSC + 30, 1'b1);
  endtask
  task automatic test_zero_band();
    start(7'h08);
    check("refZero", refCode_r, 7'h00);
  endtask
  task automatic test_over_range();
    start(7'h46);
    check("noLimit", noLimit_r, 1'b1);
    tripCnt = 0;
    pulse(40, -1);
    pulse(40, 3);
    check("noTrip", tripCnt, 0);
  endtask
  task automatic finish_test();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    test_setting_and_trip();
    test_zero_band();
    test_over_range();
    finish_test();
  end
endmodule
`default_nettype wire
